/* mrs_pkg.sv */
package mrs_pkg;
   localparam int unsigned DATA_W = 32;
   localparam int unsigned ADDR_W = 8;
   localparam int unsigned CW_W = 6;
   localparam int unsigned RL_W = 4;
   localparam int unsigned OCTET_W = 8;
   localparam int unsigned CNT_W = 8;

   // register bases; each register owns four words: plain, clear, set, invert
   localparam logic [ADDR_W-1:0] CLRT_BASE = 8'h00;
   localparam logic [ADDR_W-1:0] SADDR_BASE = 8'h10;
   localparam logic [ADDR_W-1:0] BLOCK_MASK = 8'hf0;
   localparam logic [1:0] ALIAS_PLAIN = 2'h0;
   localparam logic [1:0] ALIAS_CLR = 2'h1;
   localparam logic [1:0] ALIAS_SET = 2'h2;
   localparam logic [1:0] ALIAS_INV = 2'h3;
   localparam int unsigned ALIAS_LSB = 2;
   localparam int unsigned HALF_SEL_BIT = 1;

   // collision window / retry limit field layout
   localparam int unsigned CW_LSB = 8;
   localparam int unsigned RL_LSB = 0;
   localparam logic [CW_W-1:0] CW_RESET = 6'h37;
   localparam logic [RL_W-1:0] RL_RESET = 4'hf;

   // station address low layout
   localparam int unsigned OCT6_LSB = 8;
   localparam int unsigned OCT5_LSB = 0;

   localparam logic [DATA_W-1:0] CLRT_IMPL = 32'h0000_3f0f;
   localparam logic [DATA_W-1:0] SADDR_IMPL = 32'h0000_ffff;
   localparam logic [DATA_W-1:0] LOW_HALF = 32'h0000_ffff;
   localparam logic [DATA_W-1:0] HIGH_HALF = 32'hffff_0000;

   typedef enum logic [1:0] {
      MRS_SZ_BYTE = 2'b00,
      MRS_SZ_HALF = 2'b01,
      MRS_SZ_WORD = 2'b10
   } mrs_size_t;

   typedef enum logic [0:0] {
      MRS_IDLE = 1'b0,
      MRS_TX = 1'b1
   } mrs_tx_state_t;
endpackage

/* mrs_regs.sv */
// How it works
// - six-bit collision window at bits 13:8
// - collision window resets to fifty-five
// - four-bit retry limit; abort when exhausted
// - retry limit resets to fifteen
// - halfword and word access, clear/set/invert aliases
// - byte accesses ignored, contents unchanged
// - octet six bits 15:8, five 7:0
// - station octets load factory value at reset
// - unimplemented bits read as zero
module mrs_regs #(
   parameter logic [15:0] FACTORY_STATION_LOW = 16'h0000 // arbitrary neutral value
) (
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic [mrs_pkg::ADDR_W-1:0] bus_addr,
   input wire logic bus_wr,
   input wire logic bus_rd,
   input wire mrs_pkg::mrs_size_t bus_size,
   input wire logic [mrs_pkg::DATA_W-1:0] bus_wdata,
   output logic [mrs_pkg::DATA_W-1:0] bus_rdata,
   output logic bus_ack,
   input wire logic tx_start,
   input wire logic tx_byte,
   input wire logic tx_collision,
   input wire logic tx_done,
   output logic retry_req,
   output logic excess_abort,
   output logic late_collision,
   output logic [mrs_pkg::CW_W-1:0] collision_window_bytes,
   output logic [mrs_pkg::RL_W-1:0] retry_limit,
   output logic [mrs_pkg::OCTET_W-1:0] station_octet_six,
   output logic [mrs_pkg::OCTET_W-1:0] station_octet_five
);
   import mrs_pkg::*;

   typedef struct packed {
      logic [CW_W-1:0] cw;
      logic [RL_W-1:0] rl;
      logic [15:0] sa;
      mrs_tx_state_t st;
      logic [CNT_W-1:0] bytes;
      logic [RL_W-1:0] retries;
      logic retry;
      logic excess;
      logic late;
      logic [DATA_W-1:0] rdata;
      logic ack;
   } mrs_state_t;

   mrs_state_t cur_ff;
   mrs_state_t nxt_cur;

   // the window compare needs the byte counter wider than the window field
   if (CNT_W <= CW_W) begin : g_bad_cnt
      $error("byte counter must exceed window width");
   end

   // apply a plain, clear, set or invert alias write under a lane mask
   function automatic logic [DATA_W-1:0] alias_apply(
      input logic [DATA_W-1:0] old_v,
      input logic [DATA_W-1:0] wd,
      input logic [DATA_W-1:0] mask,
      input logic [1:0] kind
   );
      logic [DATA_W-1:0] r;
      r = old_v;
      case (kind)
         ALIAS_PLAIN: r = (old_v & ~mask) | (wd & mask);
         ALIAS_CLR: r = old_v & ~(wd & mask);
         ALIAS_SET: r = old_v | (wd & mask);
         ALIAS_INV: r = old_v ^ (wd & mask);
         default: r = old_v;
      endcase
      return r;
   endfunction

   function automatic logic hits(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] base);
      return (a & BLOCK_MASK) == base;
   endfunction

   logic [DATA_W-1:0] clrt_word;
   logic [DATA_W-1:0] sa_word;
   logic [DATA_W-1:0] lane_mask;
   logic [DATA_W-1:0] new_clrt;
   logic [DATA_W-1:0] new_sa;
   logic [1:0] kind;
   logic sized_ok;

   always_comb begin
      nxt_cur = cur_ff;
      clrt_word = '0;
      clrt_word[CW_LSB +: CW_W] = cur_ff.cw;
      clrt_word[RL_LSB +: RL_W] = cur_ff.rl;
      sa_word = '0;
      sa_word[15:0] = cur_ff.sa;
      kind = bus_addr[ALIAS_LSB +: 2];
      sized_ok = (bus_size == MRS_SZ_HALF) || (bus_size == MRS_SZ_WORD);
      if (bus_size == MRS_SZ_WORD) begin
         lane_mask = '1;
      end else if (bus_addr[HALF_SEL_BIT]) begin
         lane_mask = HIGH_HALF;
      end else begin
         lane_mask = LOW_HALF;
      end
      // unimplemented bits are dropped before storing so they always read zero
      new_clrt = alias_apply(clrt_word, bus_wdata, lane_mask, kind) & CLRT_IMPL;
      new_sa = alias_apply(sa_word, bus_wdata, lane_mask, kind) & SADDR_IMPL;

      nxt_cur.ack = bus_wr | bus_rd;
      nxt_cur.rdata = '0;
      if (bus_wr && sized_ok) begin
         if (hits(bus_addr, CLRT_BASE)) begin
            nxt_cur.cw = new_clrt[CW_LSB +: CW_W];
            nxt_cur.rl = new_clrt[RL_LSB +: RL_W];
         end else if (hits(bus_addr, SADDR_BASE)) begin
            nxt_cur.sa = new_sa[15:0];
         end
      end
      if (bus_rd && sized_ok) begin
         if (hits(bus_addr, CLRT_BASE)) begin
            nxt_cur.rdata = clrt_word & lane_mask;
         end else if (hits(bus_addr, SADDR_BASE)) begin
            nxt_cur.rdata = sa_word & lane_mask;
         end
      end

      nxt_cur.retry = 1'b0;
      nxt_cur.excess = 1'b0;
      nxt_cur.late = 1'b0;
      case (cur_ff.st)
         MRS_IDLE: begin
            if (tx_start) begin
               nxt_cur.st = MRS_TX;
               nxt_cur.bytes = '0;
            end
         end
         MRS_TX: begin
            if (tx_byte && (cur_ff.bytes != '1)) begin
               nxt_cur.bytes = cur_ff.bytes + 1'b1; // preamble and delimiter count too
            end
            if (tx_collision) begin
               nxt_cur.st = MRS_IDLE;
               if (cur_ff.bytes >= CNT_W'(cur_ff.cw)) begin
                  nxt_cur.late = 1'b1;
                  nxt_cur.retries = '0;
               end else if (cur_ff.retries >= cur_ff.rl) begin
                  nxt_cur.excess = 1'b1;
                  nxt_cur.retries = '0;
               end else begin
                  nxt_cur.retry = 1'b1;
                  nxt_cur.retries = cur_ff.retries + 1'b1;
               end
            end else if (tx_done) begin
               nxt_cur.st = MRS_IDLE;
               nxt_cur.retries = '0;
            end
         end
         default: nxt_cur.st = MRS_IDLE;
      endcase
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         cur_ff <= '0;
         cur_ff.cw <= CW_RESET;
         cur_ff.rl <= RL_RESET;
         cur_ff.sa <= FACTORY_STATION_LOW;
         cur_ff.st <= MRS_IDLE;
      end else begin
         cur_ff <= nxt_cur;
      end
   end

   assign bus_rdata = cur_ff.rdata;
   assign bus_ack = cur_ff.ack;
   assign retry_req = cur_ff.retry;
   assign excess_abort = cur_ff.excess;
   assign late_collision = cur_ff.late;
   assign collision_window_bytes = cur_ff.cw;
   assign retry_limit = cur_ff.rl;
   assign station_octet_six = cur_ff.sa[OCT6_LSB +: OCTET_W];
   assign station_octet_five = cur_ff.sa[OCT5_LSB +: OCTET_W];
endmodule // mrs_regs

/* mrs_regs_properties.sv */
module mrs_regs_chk
   import mrs_pkg::*;
#(
   parameter logic [15:0] FACT = 16'h0000
) (
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic [ADDR_W-1:0] bus_addr,
   input wire logic bus_wr,
   input wire logic bus_rd,
   input wire mrs_size_t bus_size,
   input wire logic [DATA_W-1:0] bus_rdata,
   input wire logic bus_ack,
   input wire logic tx_collision,
   input wire logic retry_req,
   input wire logic excess_abort,
   input wire logic late_collision,
   input wire logic [CW_W-1:0] collision_window_bytes,
   input wire logic [RL_W-1:0] retry_limit,
   input wire logic [OCTET_W-1:0] station_octet_six,
   input wire logic [OCTET_W-1:0] station_octet_five
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge mclk); endclocking
   a_cw_reset: assert property (sys_rst |=> collision_window_bytes == 6'h37)
      else $error("window not 0x37 after reset");
   a_rl_reset: assert property (sys_rst |=> retry_limit == 4'hf)
      else $error("limit not 0xf after reset");
   a_sa_reset: assert property (sys_rst |=> {station_octet_six, station_octet_five} == FACT)
      else $error("station not factory value after reset");
   a_ack_follows: assert property (disable iff (sys_rst) (bus_wr || bus_rd) |=> bus_ack)
      else $error("access not acknowledged");
   a_byte_keep: assert property (disable iff (sys_rst) bus_wr && bus_size == MRS_SZ_BYTE
      |=> $stable(collision_window_bytes) && $stable(retry_limit))
      else $error("byte write changed register");
   a_cw_read: assert property (disable iff (sys_rst) bus_rd && bus_addr == 8'h00 &&
      bus_size == MRS_SZ_WORD |=> bus_rdata == {18'h0, collision_window_bytes, 4'h0,
      retry_limit})
      else $error("collision register read mismatch");
   a_sa_read: assert property (disable iff (sys_rst) bus_rd && bus_addr == 8'h10 &&
      bus_size == MRS_SZ_WORD |=> bus_rdata == {16'h0, station_octet_six,
      station_octet_five})
      else $error("station register read mismatch");
   a_tx_quiet: assert property (disable iff (sys_rst) !tx_collision
      |=> !(retry_req || excess_abort || late_collision))
      else $error("outcome pulse without collision");
endmodule // mrs_regs_chk

/* mrs_txsrc.sv */
module mrs_txsrc (
   input wire logic mclk,
   output logic tx_start,
   output logic tx_byte,
   output logic tx_collision,
   output logic tx_done
);
   timeunit 1ns;
   timeprecision 1ns;
   initial {tx_start, tx_byte, tx_collision, tx_done} = 4'h0;
   // gap idles before each byte, the first included, to mimic a slow line; with no gap the byte strobe stays high
   task automatic send(input int n, input logic col, input int gap);
      @(posedge mclk) tx_start <= 1'b1;
      @(posedge mclk) tx_start <= 1'b0;
      for (int i = 0; i < n; i++) begin
         if (gap > 0) begin
            tx_byte <= 1'b0;
            repeat (gap) @(posedge mclk);
         end
         tx_byte <= 1'b1;
         @(posedge mclk);
      end
      tx_byte <= 1'b0;
      if (col) tx_collision <= 1'b1;
      else tx_done <= 1'b1;
      @(posedge mclk);
      tx_collision <= 1'b0;
      tx_done <= 1'b0;
   endtask
endmodule // mrs_txsrc

/* tb.sv */
module tb;
   import mrs_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   logic mclk = 0, sys_rst = 1, bus_wr = 0, bus_rd = 0, bus_ack;
   logic [7:0] bus_addr = 0, n_rt = 0, n_ab = 0, n_lt = 0;
   logic [31:0] bus_wdata = 0, bus_rdata;
   mrs_size_t bus_size = MRS_SZ_WORD;
   logic tx_start, tx_byte, tx_collision, tx_done, retry_req, excess_abort, late_collision;
   logic [5:0] collision_window_bytes;
   logic [3:0] retry_limit;
   logic [7:0] station_octet_six, station_octet_five;
   int n_errors = 0, cmp_count = 0;
   mrs_regs #(.FACTORY_STATION_LOW(16'h5a3c)) u_mrs_regs (.mclk(mclk), .sys_rst(sys_rst),
      .bus_addr(bus_addr), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_size(bus_size),
      .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .bus_ack(bus_ack),
      .tx_start(tx_start), .tx_byte(tx_byte), .tx_collision(tx_collision),
      .tx_done(tx_done), .retry_req(retry_req), .excess_abort(excess_abort),
      .late_collision(late_collision), .collision_window_bytes(collision_window_bytes),
      .retry_limit(retry_limit), .station_octet_six(station_octet_six),
      .station_octet_five(station_octet_five));
   mrs_txsrc u_mrs_txsrc (.mclk(mclk), .tx_start(tx_start), .tx_byte(tx_byte),
      .tx_collision(tx_collision), .tx_done(tx_done));
   initial forever #10 mclk = ~mclk;
   always @(posedge mclk) begin
      n_rt <= n_rt + 8'(retry_req === 1'b1);
      n_ab <= n_ab + 8'(excess_abort === 1'b1);
      n_lt <= n_lt + 8'(late_collision === 1'b1);
   end
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_errors++;
         $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // ack lands one edge after the request edge, so no wait loop is needed
   task automatic acc(input logic w, input logic [7:0] a, input mrs_size_t s,
      input logic [31:0] d, input logic [31:0] e);
      @(posedge mclk);
      bus_wr <= w;
      bus_rd <= !w;
      bus_addr <= a;
      bus_size <= s;
      bus_wdata <= d;
      @(posedge mclk);
      bus_wr <= 1'b0;
      bus_rd <= 1'b0;
      #1;
      check({31'h0, bus_ack}, 32'h1);
      if (!w) check(bus_rdata, e);
   endtask
   task automatic results;
      if (n_errors == 0 && cmp_count > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   initial begin
      repeat (4) @(posedge mclk);
      sys_rst <= 1'b0;
      acc(0, 8'h00, MRS_SZ_WORD, 0, 32'h0000_370f);
      acc(0, 8'h10, MRS_SZ_WORD, 0, 32'h0000_5a3c);
      acc(1, 8'h00, MRS_SZ_WORD, 32'hffff_ffff, 0);
      acc(0, 8'h00, MRS_SZ_WORD, 0, 32'h0000_3f0f);
      acc(1, 8'h00, MRS_SZ_BYTE, 32'h0, 0);
      acc(0, 8'h00, MRS_SZ_WORD, 0, 32'h0000_3f0f);
      acc(1, 8'h04, MRS_SZ_HALF, 32'h0000_0f00, 0);
      acc(1, 8'h08, MRS_SZ_WORD, 32'h0000_0100, 0);
      acc(1, 8'h0c, MRS_SZ_HALF, 32'h0000_0003, 0);
      acc(0, 8'h00, MRS_SZ_HALF, 0, 32'h0000_310c);
      acc(1, 8'h12, MRS_SZ_HALF, 32'h1234_0000, 0);
      acc(1, 8'h10, MRS_SZ_HALF, 32'h0000_a1b2, 0);
      acc(0, 8'h10, MRS_SZ_WORD, 0, 32'h0000_a1b2);
      check({16'h0, station_octet_six, station_octet_five}, 32'h0000_a1b2);
      acc(0, 8'h20, MRS_SZ_WORD, 0, 0);
      acc(1, 8'h00, MRS_SZ_WORD, 32'h0000_0402, 0);
      repeat (3) u_mrs_txsrc.send(2, 1'b1, 0);
      u_mrs_txsrc.send(3, 1'b1, 2);
      u_mrs_txsrc.send(4, 1'b1, 0);
      // a clean finish clears the retry count, so two more collisions still retry
      u_mrs_txsrc.send(2, 1'b1, 0);
      u_mrs_txsrc.send(2, 1'b0, 0);
      repeat (2) u_mrs_txsrc.send(2, 1'b1, 0);
      repeat (2) @(posedge mclk);
      check({8'h0, n_rt, n_ab, n_lt}, 32'h0006_0101);
      results();
   end
endmodule // tb
bind mrs_regs mrs_regs_chk #(.FACT(FACTORY_STATION_LOW)) u_chk (.mclk(mclk),
   .sys_rst(sys_rst), .bus_addr(bus_addr), .bus_wr(bus_wr), .bus_rd(bus_rd),
   .bus_size(bus_size), .bus_rdata(bus_rdata), .bus_ack(bus_ack),
   .tx_collision(tx_collision), .retry_req(retry_req), .excess_abort(excess_abort),
   .late_collision(late_collision), .collision_window_bytes(collision_window_bytes),
   .retry_limit(retry_limit), .station_octet_six(station_octet_six),
   .station_octet_five(station_octet_five));
